// file: hw/exec_pkg.sv
/*
 * Shared constants and types for the branch, skip, I/O-bit and shift
 * execution unit: operation codes, status bit positions, reset values
 * and cycle counts.
 * Assumes the decoder in front of the unit has already split the
 * instruction word into the fields that the unit's ports carry.
 */
package exec_pkg;

    // ========================================
    // operations handled by this unit
    typedef enum logic [4:0] {
        op_none,
        skip_on_reg_bit_high,
        skip_on_io_bit_low,
        skip_on_io_bit_high,
        branch_on_flag_high,
        branch_on_flag_low,
        branch_when_equal,
        branch_when_unequal,
        branch_on_carry_high,
        branch_on_carry_low,
        branch_unsigned_at_least,
        branch_unsigned_below,
        branch_when_negative,
        branch_when_positive,
        branch_signed_at_least,
        branch_signed_below,
        branch_half_carry_high,
        branch_half_carry_low,
        branch_transfer_bit_high,
        branch_transfer_bit_low,
        branch_overflow_high,
        branch_overflow_low,
        branch_irq_enabled,
        branch_irq_disabled,
        io_bit_set_op,
        io_bit_clear_op,
        shift_up_logical,
        shift_down_logical
    } op_t;

    // ========================================
    // status_byte bit positions
    localparam int unsigned FLAG_C = 0;
    localparam int unsigned FLAG_Z = 1;
    localparam int unsigned FLAG_N = 2;
    localparam int unsigned FLAG_V = 3;
    localparam int unsigned FLAG_S = 4;
    localparam int unsigned FLAG_H = 5;
    localparam int unsigned FLAG_T = 6;
    localparam int unsigned FLAG_I = 7;

    // ========================================
    // reset values
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // ========================================
    // cycles per operation, counted from acceptance
    localparam logic [1:0] CYC_PLAIN      = 2'h1;
    localparam logic [1:0] CYC_TAKEN      = 2'h2;
    localparam logic [1:0] CYC_SKIP_SHORT = 2'h2;
    localparam logic [1:0] CYC_SKIP_LONG  = 2'h3;
    localparam logic [1:0] CYC_IO_BIT     = 2'h2;
    localparam logic [1:0] CYC_SHIFT      = 2'h1;

    // ========================================
    // relative branch offset width
    localparam int unsigned OFS_W = 7;

endpackage

// file: hw/cond_eval.sv
/*
 * Condition evaluator: decides whether a skip or conditional branch
 * is taken, from the status byte and the tested register bits.
 * Assumes gpr_value and io_value already hold the addressed operand.
 */
`timescale 1ns/1ps

module cond_eval (
    // operation
    input  wire exec_pkg::op_t op,
    input  wire logic [2:0]    bit_idx,
    input  wire logic [2:0]    flag_idx,
    // operands
    input  wire logic [7:0]    status,
    input  wire logic [7:0]    gpr_value,
    input  wire logic [7:0]    io_value,
    // result
    output logic               take
);

    function automatic logic pick(input logic [7:0] v,
                                  input int unsigned pos);
        pick = v[pos];
    endfunction

    logic sgn;

    always_comb begin
        sgn  = pick(status, exec_pkg::FLAG_N) ^
               pick(status, exec_pkg::FLAG_V);
        take = 1'b0;
        unique case (op)
            exec_pkg::skip_on_reg_bit_high: take = gpr_value[bit_idx];
            exec_pkg::skip_on_io_bit_low:   take = ~io_value[bit_idx];
            exec_pkg::skip_on_io_bit_high:  take = io_value[bit_idx];
            exec_pkg::branch_on_flag_high:  take = status[flag_idx];
            exec_pkg::branch_on_flag_low:   take = ~status[flag_idx];
            exec_pkg::branch_when_equal:
                take = pick(status, exec_pkg::FLAG_Z);
            exec_pkg::branch_when_unequal:
                take = ~pick(status, exec_pkg::FLAG_Z);
            exec_pkg::branch_on_carry_high, exec_pkg::branch_unsigned_below:
                take = pick(status, exec_pkg::FLAG_C);
            exec_pkg::branch_on_carry_low, exec_pkg::branch_unsigned_at_least:
                take = ~pick(status, exec_pkg::FLAG_C);
            exec_pkg::branch_when_negative:
                take = pick(status, exec_pkg::FLAG_N);
            exec_pkg::branch_when_positive:
                take = ~pick(status, exec_pkg::FLAG_N);
            exec_pkg::branch_signed_at_least: take = ~sgn;
            exec_pkg::branch_signed_below:    take = sgn;
            exec_pkg::branch_half_carry_high:
                take = pick(status, exec_pkg::FLAG_H);
            exec_pkg::branch_half_carry_low:
                take = ~pick(status, exec_pkg::FLAG_H);
            exec_pkg::branch_transfer_bit_high:
                take = pick(status, exec_pkg::FLAG_T);
            exec_pkg::branch_transfer_bit_low:
                take = ~pick(status, exec_pkg::FLAG_T);
            exec_pkg::branch_overflow_high:
                take = pick(status, exec_pkg::FLAG_V);
            exec_pkg::branch_overflow_low:
                take = ~pick(status, exec_pkg::FLAG_V);
            exec_pkg::branch_irq_enabled:
                take = pick(status, exec_pkg::FLAG_I);
            exec_pkg::branch_irq_disabled:
                take = ~pick(status, exec_pkg::FLAG_I);
            default: take = 1'b0;
        endcase
    end

endmodule

// file: hw/branch_skip_bitop_exec.sv
/*
 * Execution unit for skips, conditional relative branches, I/O bit
 * set/clear and logical shifts. Owns the program counter and the
 * status byte; drives write strobes toward register file and I/O.
 * Assumes a same-clock decoder that presents pre-split fields and the
 * addressed operand values, and holds an instruction until accepted.
 */
`timescale 1ns/1ps

// What this block does
// - register bit high skips next instruction
// - I/O bit low skips next instruction
// - I/O bit high skips, else falls through
// - flag high branches by offset plus one
// - flag low branch, one or two cycles
// - equal branch while zero flag set
// - unequal branch while zero flag clear
// - carry high and unsigned below branch on carry
// - carry low and unsigned at least branch
// - negative and positive branches test N
// - signed at least branch when N^V zero
// - signed below branches when N xor V one
// - half carry branch pair tests H
// - transfer bit branch pair tests T
// - overflow branch pair tests V
// - irq branch pair tests global enable
// - set I/O bit, flags kept, two cycles
// - clear I/O bit, flags kept, two cycles
// - shift left, zero in, flags, one cycle
// - shift right, zero in, flags, one cycle
module branch_skip_bitop_exec #(
    parameter int unsigned PC_W = 12
) (
    // clock and reset
    input  wire logic            clk,
    input  wire logic            srst,
    // decoded instruction
    input  wire logic            instr_valid,
    input  wire exec_pkg::op_t   op,
    input  wire logic [2:0]      bit_idx,
    input  wire logic [2:0]      flag_idx,
    input  wire logic [6:0]      branch_ofs,
    input  wire logic [5:0]      io_addr,
    input  wire logic            next_two_word,
    input  wire logic [7:0]      gpr_value,
    input  wire logic [7:0]      io_value,
    // loads from the rest of the core
    input  wire logic            pc_load_en,
    input  wire logic [PC_W-1:0] pc_load_value,
    input  wire logic            status_load_en,
    input  wire logic [7:0]      status_load_value,
    // core state
    output logic                 busy_q,
    output logic [PC_W-1:0]      pc_q,
    output logic [7:0]           status_q,
    // register file write
    output logic                 gpr_we_q,
    output logic [7:0]           gpr_wdata_q,
    // I/O write
    output logic                 io_we_q,
    output logic [5:0]           io_waddr_q,
    output logic [7:0]           io_wdata_q
);

    // ========================================
    // helpers

    function automatic logic [PC_W-1:0] branch_target(
        input logic [PC_W-1:0] pc,
        input logic [6:0]      ofs
    );
        logic [PC_W-1:0] sx;
        sx = {{(PC_W-exec_pkg::OFS_W){ofs[6]}}, ofs};
        branch_target = pc + sx + PC_W'(1);
    endfunction

    function automatic logic is_branch(input exec_pkg::op_t o);
        is_branch = (o >= exec_pkg::branch_on_flag_high) &&
                    (o <= exec_pkg::branch_irq_disabled);
    endfunction

    function automatic logic is_skip(input exec_pkg::op_t o);
        is_skip = (o == exec_pkg::skip_on_reg_bit_high) ||
                  (o == exec_pkg::skip_on_io_bit_low) ||
                  (o == exec_pkg::skip_on_io_bit_high);
    endfunction

    // ========================================
    // condition

    logic take;
    logic accept;

    cond_eval u_cond (
        .op        (op),
        .bit_idx   (bit_idx),
        .flag_idx  (flag_idx),
        .status    (status_q),
        .gpr_value (gpr_value),
        .io_value  (io_value),
        .take      (take)
    );

    assign accept = instr_valid && !busy_q;

    // ========================================
    // sequencing: pc and occupancy

    logic [1:0]      stall_q;
    logic [1:0]      stall_d;
    logic            busy_d;
    logic [PC_W-1:0] pc_d;
    logic [1:0]      cycles;

    always_comb begin
        cycles  = exec_pkg::CYC_PLAIN;
        pc_d    = pc_q;
        if (pc_load_en) begin
            pc_d = pc_load_value;
        end
        if (accept) begin
            pc_d = pc_q + PC_W'(1);
            if (is_branch(op) && take) begin
                pc_d   = branch_target(pc_q, branch_ofs);
                cycles = exec_pkg::CYC_TAKEN;
            end else if (is_skip(op) && take) begin
                // skipped instruction length sets the step
                if (next_two_word) begin
                    pc_d   = pc_q + PC_W'(3);
                    cycles = exec_pkg::CYC_SKIP_LONG;
                end else begin
                    pc_d   = pc_q + PC_W'(2);
                    cycles = exec_pkg::CYC_SKIP_SHORT;
                end
            end else if (op == exec_pkg::io_bit_set_op ||
                         op == exec_pkg::io_bit_clear_op) begin
                cycles = exec_pkg::CYC_IO_BIT;
            end else if (op == exec_pkg::shift_up_logical ||
                         op == exec_pkg::shift_down_logical) begin
                cycles = exec_pkg::CYC_SHIFT;
            end
        end
        if (accept) begin
            stall_d = cycles - 2'h1;
        end else if (stall_q != 2'h0) begin
            stall_d = stall_q - 2'h1;
        end else begin
            stall_d = 2'h0;
        end
        busy_d = (stall_d != 2'h0);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            stall_q <= 2'h0;
            busy_q  <= 1'b0;
            pc_q    <= '0;
        end else begin
            stall_q <= stall_d;
            busy_q  <= busy_d;
            pc_q    <= pc_d;
        end
    end

    // ========================================
    // data path: status byte, register and I/O writes

    logic [7:0] status_d;
    logic       gpr_we_d;
    logic [7:0] gpr_wdata_d;
    logic       io_we_d;
    logic [5:0] io_waddr_d;
    logic [7:0] io_wdata_d;
    logic [7:0] res;
    logic       cout;

    always_comb begin
        status_d    = status_load_en ? status_load_value : status_q;
        gpr_we_d    = 1'b0;
        gpr_wdata_d = gpr_wdata_q;
        io_we_d     = 1'b0;
        io_waddr_d  = io_waddr_q;
        io_wdata_d  = io_wdata_q;
        res         = 8'h00;
        cout        = 1'b0;
        if (accept) begin
            unique case (op)
                exec_pkg::io_bit_set_op: begin
                    // status untouched on purpose
                    io_we_d    = 1'b1;
                    io_waddr_d = io_addr;
                    io_wdata_d = io_value | (8'h01 << bit_idx);
                end
                exec_pkg::io_bit_clear_op: begin
                    io_we_d    = 1'b1;
                    io_waddr_d = io_addr;
                    io_wdata_d = io_value & ~(8'h01 << bit_idx);
                end
                exec_pkg::shift_up_logical,
                exec_pkg::shift_down_logical: begin
                    if (op == exec_pkg::shift_up_logical) begin
                        res  = {gpr_value[6:0], 1'b0};
                        cout = gpr_value[7];
                    end else begin
                        res  = {1'b0, gpr_value[7:1]};
                        cout = gpr_value[0];
                    end
                    gpr_we_d    = 1'b1;
                    gpr_wdata_d = res;
                    // shift result outranks a same-cycle status load
                    status_d[exec_pkg::FLAG_C] = cout;
                    status_d[exec_pkg::FLAG_Z] = (res == 8'h00);
                    status_d[exec_pkg::FLAG_N] = res[7];
                    status_d[exec_pkg::FLAG_V] = res[7] ^ cout;
                end
                default: begin
                    gpr_we_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            status_q    <= exec_pkg::STATUS_RESET;
            gpr_we_q    <= 1'b0;
            gpr_wdata_q <= 8'h00;
            io_we_q     <= 1'b0;
            io_waddr_q  <= 6'h00;
            io_wdata_q  <= 8'h00;
        end else begin
            status_q    <= status_d;
            gpr_we_q    <= gpr_we_d;
            gpr_wdata_q <= gpr_wdata_d;
            io_we_q     <= io_we_d;
            io_waddr_q  <= io_waddr_d;
            io_wdata_q  <= io_wdata_d;
        end
    end

    // ========================================
    // assertions

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    a_branch_taken_target: assert property (
        accept && is_branch(op) && take |=>
            pc_q == branch_target($past(pc_q), $past(branch_ofs)))
        else $error("taken branch target wrong");

    a_branch_taken_time: assert property (
        accept && is_branch(op) && take |=> busy_q ##1 !busy_q)
        else $error("taken branch not two cycles");

    a_branch_fall_through: assert property (
        accept && is_branch(op) && !take |=>
            !busy_q && pc_q == $past(pc_q) + PC_W'(1))
        else $error("untaken branch wrong");

    a_skip_long_step: assert property (
        accept && is_skip(op) && take && next_two_word |=>
            pc_q == $past(pc_q) + PC_W'(3) ##0 busy_q[*2] ##1 !busy_q)
        else $error("long skip wrong");

    a_skip_short_step: assert property (
        accept && is_skip(op) && take && !next_two_word |=>
            pc_q == $past(pc_q) + PC_W'(2) ##0 busy_q ##1 !busy_q)
        else $error("short skip wrong");

    a_io_set_write: assert property (
        accept && op == exec_pkg::io_bit_set_op && !status_load_en |=>
            io_we_q && io_wdata_q[$past(bit_idx)] &&
            status_q == $past(status_q) && busy_q ##1 !busy_q)
        else $error("io bit set wrong");

    a_io_clear_write: assert property (
        accept && op == exec_pkg::io_bit_clear_op && !status_load_en |=>
            io_we_q && !io_wdata_q[$past(bit_idx)] &&
            io_waddr_q == $past(io_addr) && status_q == $past(status_q))
        else $error("io bit clear wrong");

    a_shift_up_flags: assert property (
        accept && op == exec_pkg::shift_up_logical |=>
            gpr_we_q && !busy_q &&
            gpr_wdata_q == {$past(gpr_value[6:0]), 1'b0} &&
            status_q[exec_pkg::FLAG_C] == $past(gpr_value[7]))
        else $error("shift left wrong");

    a_shift_down_flags: assert property (
        accept && op == exec_pkg::shift_down_logical |=>
            gpr_we_q && gpr_wdata_q[7] == 1'b0 &&
            status_q[exec_pkg::FLAG_N] == 1'b0 &&
            status_q[exec_pkg::FLAG_C] == $past(gpr_value[0]))
        else $error("shift right wrong");

    c_branch_taken: cover property (accept && is_branch(op) && take);
    c_skip_long:    cover property (accept && is_skip(op) && take &&
                                    next_two_word);
    c_io_set:       cover property (accept &&
                                    op == exec_pkg::io_bit_set_op);
    c_shift_up:     cover property (accept &&
                                    op == exec_pkg::shift_up_logical);

endmodule

// file: tb/test_branch_skip_bitop_exec.sv
/*
 * Self-checking bench for the skip, branch, I/O-bit and shift unit.
 * Assumes the unit accepts on instr_valid && !busy_q, shows results one
 * edge later, and that pc and status can be preloaded through the
 * external load ports in the cycle before an operation.
 */
`timescale 1ns/1ps

module test_branch_skip_bitop_exec;

    // ========================================
    // parameters and signals
    localparam int PC_W  = 12;
    localparam int LIMIT = 20000;

    logic                clk;
    logic                srst;
    logic                instr_valid;
    exec_pkg::op_t       op;
    logic [2:0]          bit_idx;
    logic [2:0]          flag_idx;
    logic [6:0]          branch_ofs;
    logic [5:0]          io_addr;
    logic                next_two_word;
    logic [7:0]          gpr_value;
    logic [7:0]          io_value;
    logic                pc_load_en;
    logic [PC_W-1:0]     pc_load_value;
    logic                status_load_en;
    logic [7:0]          status_load_value;
    logic                busy_q;
    logic [PC_W-1:0]     pc_q;
    logic [7:0]          status_q;
    logic                gpr_we_q;
    logic [7:0]          gpr_wdata_q;
    logic                io_we_q;
    logic [5:0]          io_waddr_q;
    logic [7:0]          io_wdata_q;
    int                  err_total;
    int                  samples_checked;
    int                  cycle_count;
    logic [15:0]         lfsr_q;
    logic [7:0]          r [0:7];

    branch_skip_bitop_exec #(.PC_W(PC_W)) u_dut (
        .clk(clk), .srst(srst), .instr_valid(instr_valid), .op(op),
        .bit_idx(bit_idx), .flag_idx(flag_idx), .branch_ofs(branch_ofs),
        .io_addr(io_addr), .next_two_word(next_two_word),
        .gpr_value(gpr_value), .io_value(io_value),
        .pc_load_en(pc_load_en), .pc_load_value(pc_load_value),
        .status_load_en(status_load_en),
        .status_load_value(status_load_value), .busy_q(busy_q),
        .pc_q(pc_q), .status_q(status_q), .gpr_we_q(gpr_we_q),
        .gpr_wdata_q(gpr_wdata_q), .io_we_q(io_we_q),
        .io_waddr_q(io_waddr_q), .io_wdata_q(io_wdata_q)
    );

    always #12.5 clk = ~clk;

    // ========================================
    // hang guard
    always @(posedge clk) begin
        cycle_count++;
        if (cycle_count >= LIMIT) begin
            err_total++;
            wrap_up();
        end
    end

    // ========================================
    // helpers
    function automatic logic [7:0] rnd();
        lfsr_q = lfsr_q[0] ? (lfsr_q >> 1) ^ 16'hb400 : lfsr_q >> 1;
        return lfsr_q[7:0];
    endfunction

    function automatic logic taken_ref(exec_pkg::op_t o, logic [7:0] s,
                                       logic [2:0] b, logic [2:0] f,
                                       logic [7:0] gv, logic [7:0] iv);
        logic nv;
        nv = s[exec_pkg::FLAG_N] ^ s[exec_pkg::FLAG_V];
        case (o)
            exec_pkg::skip_on_reg_bit_high:     return gv[b];
            exec_pkg::skip_on_io_bit_low:       return !iv[b];
            exec_pkg::skip_on_io_bit_high:      return iv[b];
            exec_pkg::branch_on_flag_high:      return s[f];
            exec_pkg::branch_on_flag_low:       return !s[f];
            exec_pkg::branch_when_equal:        return s[exec_pkg::FLAG_Z];
            exec_pkg::branch_when_unequal:      return !s[exec_pkg::FLAG_Z];
            exec_pkg::branch_on_carry_high,
            exec_pkg::branch_unsigned_below:    return s[exec_pkg::FLAG_C];
            exec_pkg::branch_on_carry_low,
            exec_pkg::branch_unsigned_at_least: return !s[exec_pkg::FLAG_C];
            exec_pkg::branch_when_negative:     return s[exec_pkg::FLAG_N];
            exec_pkg::branch_when_positive:     return !s[exec_pkg::FLAG_N];
            exec_pkg::branch_signed_at_least:   return !nv;
            exec_pkg::branch_signed_below:      return nv;
            exec_pkg::branch_half_carry_high:   return s[exec_pkg::FLAG_H];
            exec_pkg::branch_half_carry_low:    return !s[exec_pkg::FLAG_H];
            exec_pkg::branch_transfer_bit_high: return s[exec_pkg::FLAG_T];
            exec_pkg::branch_transfer_bit_low:  return !s[exec_pkg::FLAG_T];
            exec_pkg::branch_overflow_high:     return s[exec_pkg::FLAG_V];
            exec_pkg::branch_overflow_low:      return !s[exec_pkg::FLAG_V];
            exec_pkg::branch_irq_enabled:       return s[exec_pkg::FLAG_I];
            exec_pkg::branch_irq_disabled:      return !s[exec_pkg::FLAG_I];
            default:                            return 1'b0;
        endcase
    endfunction

    task automatic chk(input string name, input logic [15:0] exp,
                       input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic preload(input logic [7:0] st, input logic [PC_W-1:0] pc0);
        @(posedge clk);
        pc_load_en        <= 1'b1;
        pc_load_value     <= pc0;
        status_load_en    <= 1'b1;
        status_load_value <= st;
        instr_valid       <= 1'b0;
        @(posedge clk);
        pc_load_en        <= 1'b0;
        status_load_en    <= 1'b0;
    endtask

    // ========================================
    // one operation: preload, accept, compare outputs and cycle count
    task automatic exec_one(input exec_pkg::op_t o, input logic [7:0] st,
                            input logic [PC_W-1:0] pc0, input logic [2:0] b,
                            input logic [2:0] f, input logic [6:0] ofs,
                            input logic two, input logic [7:0] gv,
                            input logic [7:0] iv, input logic [5:0] ia);
        logic            tk;
        logic            shl;
        logic [PC_W-1:0] epc;
        logic [7:0]      est;
        logic [7:0]      res;
        int              ecyc;
        int              cyc;
        preload(st, pc0);
        instr_valid   <= 1'b1;
        op            <= o;
        bit_idx       <= b;
        flag_idx      <= f;
        branch_ofs    <= ofs;
        next_two_word <= two;
        gpr_value     <= gv;
        io_value      <= iv;
        io_addr       <= ia;
        @(posedge clk);
        instr_valid   <= 1'b0;
        #1;
        tk   = taken_ref(o, st, b, f, gv, iv);
        epc  = pc0 + 1'b1;
        est  = st;
        ecyc = 1;
        if (tk && o >= exec_pkg::branch_on_flag_high) begin
            epc  = pc0 + {{(PC_W-7){ofs[6]}}, ofs} + 1'b1;
            ecyc = 2;
        end else if (tk) begin
            epc  = pc0 + (two ? 12'h003 : 12'h002);
            ecyc = two ? 3 : 2;
        end
        if (o == exec_pkg::io_bit_set_op || o == exec_pkg::io_bit_clear_op) begin
            ecyc = 2;
            res  = (o == exec_pkg::io_bit_set_op) ? iv | (8'h01 << b)
                                                  : iv & ~(8'h01 << b);
            chk("io_we_q", 16'h0001, 16'(io_we_q));
            chk("io_waddr_q", 16'(ia), 16'(io_waddr_q));
            chk("io_wdata_q", 16'(res), 16'(io_wdata_q));
        end else begin
            chk("io_we_q", 16'h0000, 16'(io_we_q));
        end
        if (o == exec_pkg::shift_up_logical ||
            o == exec_pkg::shift_down_logical) begin
            shl = (o == exec_pkg::shift_up_logical);
            res = shl ? {gv[6:0], 1'b0} : {1'b0, gv[7:1]};
            est[exec_pkg::FLAG_C] = shl ? gv[7] : gv[0];
            est[exec_pkg::FLAG_Z] = (res == 8'h00);
            est[exec_pkg::FLAG_N] = res[7];
            est[exec_pkg::FLAG_V] = res[7] ^ est[exec_pkg::FLAG_C];
            chk("gpr_we_q", 16'h0001, 16'(gpr_we_q));
            chk("gpr_wdata_q", 16'(res), 16'(gpr_wdata_q));
        end else begin
            chk("gpr_we_q", 16'h0000, 16'(gpr_we_q));
        end
        chk("pc_q", 16'(epc), 16'(pc_q));
        chk("status_q", 16'(est), 16'(status_q));
        chk("busy_q", 16'(ecyc > 1), 16'(busy_q));
        cyc = 1;
        while (busy_q === 1'b1 && cyc < 8) begin
            @(posedge clk);
            #1;
            cyc++;
        end
        chk("cycles", 16'(ecyc), 16'(cyc));
        if (cyc > 1)
            chk("strobes", 16'h0000, 16'({io_we_q, gpr_we_q}));
    endtask

    // ========================================
    // main sequence
    initial begin
        clk = 1'b0; srst = 1'b1; instr_valid = 1'b0; op = exec_pkg::op_none;
        bit_idx = 3'h0; flag_idx = 3'h0; branch_ofs = 7'h00; io_addr = 6'h00;
        next_two_word = 1'b0; gpr_value = 8'h00; io_value = 8'h00;
        pc_load_en = 1'b0; pc_load_value = '0; status_load_en = 1'b0;
        status_load_value = 8'h00; err_total = 0; samples_checked = 0;
        cycle_count = 0; lfsr_q = 16'h1313;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        #1;
        chk("reset", 16'h0000, 16'({busy_q, gpr_we_q, io_we_q, status_q}));
        chk("reset pc_q", 16'h0000, 16'(pc_q));
        // corner cases: zero result, carry out, offset extremes, long skip
        exec_one(exec_pkg::shift_up_logical, 8'hf0, 12'h010, 3'h0, 3'h0,
                 7'h00, 1'b0, 8'h80, 8'h00, 6'h00);
        exec_one(exec_pkg::shift_down_logical, 8'h3f, 12'h020, 3'h0, 3'h0,
                 7'h00, 1'b0, 8'h01, 8'h00, 6'h00);
        exec_one(exec_pkg::branch_when_equal, 8'h02, 12'h000, 3'h0, 3'h0,
                 7'h40, 1'b0, 8'h00, 8'h00, 6'h00);
        exec_one(exec_pkg::branch_when_unequal, 8'h00, 12'hffe, 3'h0, 3'h0,
                 7'h3f, 1'b0, 8'h00, 8'h00, 6'h00);
        exec_one(exec_pkg::skip_on_reg_bit_high, 8'h00, 12'h100, 3'h7, 3'h0,
                 7'h00, 1'b1, 8'h80, 8'h00, 6'h00);
        exec_one(exec_pkg::io_bit_set_op, 8'hff, 12'h200, 3'h7, 3'h0,
                 7'h00, 1'b0, 8'h00, 8'h00, 6'h3f);
        exec_one(exec_pkg::io_bit_clear_op, 8'h00, 12'h200, 3'h0, 3'h0,
                 7'h00, 1'b0, 8'h00, 8'hff, 6'h00);
        // random sweep over every operation
        for (int k = 1; k <= int'(exec_pkg::shift_down_logical); k++) begin
            for (int n = 0; n < 12; n++) begin
                for (int i = 0; i < 8; i++)
                    r[i] = rnd();
                exec_one(exec_pkg::op_t'(k), r[0], {r[1][3:0], r[2]},
                         r[3][2:0], r[3][5:3], r[4][6:0], r[3][6], r[5],
                         r[6], r[7][5:0]);
            end
        end
        // request held while busy is ignored, then accepted once
        preload(8'h00, 12'h100);
        instr_valid <= 1'b1;
        op          <= exec_pkg::branch_when_unequal;
        branch_ofs  <= 7'h05;
        @(posedge clk);
        op <= exec_pkg::op_none;
        #1;
        chk("held pc_q", 16'h0106, 16'(pc_q));
        chk("held busy_q", 16'h0001, 16'(busy_q));
        @(posedge clk);
        #1;
        chk("refused pc_q", 16'h0106, 16'(pc_q));
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
        chk("after pc_q", 16'h0107, 16'(pc_q));
        // reset in the middle of a long skip
        preload(8'h00, 12'h300);
        instr_valid   <= 1'b1;
        op            <= exec_pkg::skip_on_io_bit_low;
        io_value      <= 8'h00;
        next_two_word <= 1'b1;
        @(posedge clk);
        instr_valid <= 1'b0;
        srst        <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        #1;
        chk("midreset", 16'h0000, 16'({busy_q, gpr_we_q, io_we_q, status_q}));
        chk("midreset pc_q", 16'h0000, 16'(pc_q));
        chk("midreset data", 16'h0000, {gpr_wdata_q, io_wdata_q});
        exec_one(exec_pkg::skip_on_io_bit_high, 8'h00, 12'h040, 3'h2, 3'h0,
                 7'h00, 1'b0, 8'h00, 8'h04, 6'h00);
        exec_one(exec_pkg::skip_on_io_bit_low, 8'h00, 12'h040, 3'h2, 3'h0,
                 7'h00, 1'b1, 8'h00, 8'hfb, 6'h00);
        wrap_up();
    end

endmodule
